/* File: verilog/sxe_exec.sv */
// Execution slice for nibble swap, zero skips, table reads and XOR.
// Assumes the decoder presents one operation per issue pulse, a data
// memory that returns the addressed byte combinationally on mem_rd_in,
// and a program memory that returns the addressed word combinationally on rom_data_in.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module sxe_exec
    import sxe_pkg::*;
#(
    parameter int DATA_W = SXE_DATA_W,
    parameter int ROM_W  = SXE_ROM_W,
    parameter int PC_W   = SXE_PC_W
) (
    input  wire logic              clk_in,        // Instruction clock.
    input  wire logic              rstn_in,       // Async active-low reset.
    input  wire logic              issue_in,      // Operation valid pulse.
    input  wire logic [3:0]        op_in,         // Operation code.
    input  wire logic [2:0]        bit_sel_in,    // Bit index for bit test.
    input  wire logic [DATA_W-1:0] imm_in,        // Immediate operand.
    input  wire logic [DATA_W-1:0] mem_rd_in,     // Addressed memory byte.
    input  wire logic [PC_W-1:0]   pc_in,         // Current program counter.
    input  wire logic [DATA_W-1:0] tab_ptr_in,    // Table pointer value.
    input  wire logic [ROM_W-1:0]  rom_data_in,   // Program memory word.
    input  wire logic [3:0]        flags_in,      // OV, Z, AC, C now.
    output logic                   busy_out,      // Not ready for issue.
    output logic                   flush_out,     // Discard prefetch pulse.
    output logic                   mem_we_out,    // Memory write pulse.
    output logic [DATA_W-1:0]      mem_wd_out,    // Memory write data.
    output logic                   rom_re_out,    // Program memory read.
    output logic [PC_W-1:0]        rom_addr_out,  // Program memory address.
    output logic [DATA_W-1:0]      acc_out,       // Accumulator.
    output logic [ROM_W-DATA_W-1:0] tab_hi_out,   // Table high 7-bit register.
    output logic                   flags_we_out,  // Flag write pulse.
    output logic [3:0]             flags_out      // Flags to write.
);
    localparam int HI_W = ROM_W - DATA_W;

    logic           rstn_s;
    sxe_state_e     state_q;
    logic [DATA_W-1:0] acc_q;
    logic [HI_W-1:0]   tab_hi_q;
    logic           mem_we_q;
    logic [DATA_W-1:0] mem_wd_q;
    logic           flags_we_q;
    logic [3:0]     flags_q;
    logic           flush_q;
    logic           rom_re_q;
    logic [PC_W-1:0] rom_addr_q;
    logic [DATA_W-1:0] swapped;
    logic [DATA_W-1:0] xor_acc_mem;
    logic [DATA_W-1:0] xor_acc_imm;
    logic           byte_zero;
    logic           bit_zero;
    logic           skip;
    logic           go;

    sxe_rst_sync u_rst (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .rstn_out (rstn_s)
    );

    //////////////////////////////////////////////////////////////////////////
    // Operand paths.
    assign swapped     = {mem_rd_in[3:0], mem_rd_in[7:4]};
    assign xor_acc_mem = acc_q ^ mem_rd_in;
    assign xor_acc_imm = acc_q ^ imm_in;
    assign byte_zero   = (mem_rd_in == '0);
    assign bit_zero    = ~mem_rd_in[bit_sel_in];
    assign go          = issue_in && (state_q == SXE_ST_EXEC);

    always_comb begin
        case (op_in)
            SXE_OP_SKZ,
            SXE_OP_CPSKZ:  skip = byte_zero;
            SXE_OP_BITSKZ: skip = bit_zero;
            default:       skip = 1'b0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Sequencer: a skip or a table read costs one extra cycle.
    always_ff @(posedge clk_in or negedge rstn_s) begin
        if (!rstn_s) begin
            state_q <= SXE_ST_EXEC;
        end else begin
            case (state_q)
                SXE_ST_EXEC: begin
                    if (go && skip) begin
                        state_q <= SXE_ST_DUMMY;
                    end else if (go && (op_in == SXE_OP_TRDC ||
                                        op_in == SXE_OP_TRDL)) begin
                        state_q <= SXE_ST_TABLE;
                    end
                end
                SXE_ST_DUMMY: state_q <= SXE_ST_EXEC;
                SXE_ST_TABLE: state_q <= SXE_ST_EXEC;
                default:      state_q <= SXE_ST_EXEC;
            endcase
        end
    end

    // The flush is a pulse so the fetch unit drops exactly one word.
    always_ff @(posedge clk_in or negedge rstn_s) begin
        if (!rstn_s) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= go && skip;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Program memory read for table operations.
    always_ff @(posedge clk_in or negedge rstn_s) begin
        if (!rstn_s) begin
            rom_re_q   <= 1'b0;
            rom_addr_q <= '0;
        end else begin
            rom_re_q <= go && (op_in == SXE_OP_TRDC || op_in == SXE_OP_TRDL);
            if (go && op_in == SXE_OP_TRDC) begin
                rom_addr_q <= {pc_in[PC_W-1:DATA_W], tab_ptr_in};
            end else if (go && op_in == SXE_OP_TRDL) begin
                rom_addr_q <= {{(PC_W-DATA_W){1'b1}}, tab_ptr_in};
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Accumulator.
    always_ff @(posedge clk_in or negedge rstn_s) begin
        if (!rstn_s) begin
            acc_q <= SXE_ACC_RST;
        end else if (go) begin
            case (op_in)
                SXE_OP_SWAP_ACC: acc_q <= swapped;
                SXE_OP_CPSKZ: acc_q <= mem_rd_in;
                SXE_OP_XORA:  acc_q <= xor_acc_mem;
                SXE_OP_XORI:  acc_q <= xor_acc_imm;
                default:      acc_q <= acc_q;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Data memory write port.
    always_ff @(posedge clk_in or negedge rstn_s) begin
        if (!rstn_s) begin
            mem_we_q <= 1'b0;
            mem_wd_q <= '0;
        end else begin
            mem_we_q <= 1'b0;
            if (state_q == SXE_ST_TABLE) begin
                mem_we_q <= 1'b1;
                mem_wd_q <= rom_data_in[DATA_W-1:0];
            end else if (go && op_in == SXE_OP_SWAP) begin
                mem_we_q <= 1'b1;
                mem_wd_q <= swapped;
            end else if (go && op_in == SXE_OP_XOR_MEM) begin
                mem_we_q <= 1'b1;
                mem_wd_q <= xor_acc_mem;
            end
        end
    end

    // Table high register.
    always_ff @(posedge clk_in or negedge rstn_s) begin
        if (!rstn_s) begin
            tab_hi_q <= SXE_TABHI_RST;
        end else if (state_q == SXE_ST_TABLE) begin
            tab_hi_q <= rom_data_in[ROM_W-1:DATA_W];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Flags: only XOR writes, and only the zero bit changes.
    always_ff @(posedge clk_in or negedge rstn_s) begin
        if (!rstn_s) begin
            flags_we_q <= 1'b0;
            flags_q    <= SXE_FLAG_RST;
        end else begin
            flags_we_q <= 1'b0;
            if (go && (op_in == SXE_OP_XORA || op_in == SXE_OP_XOR_MEM)) begin
                flags_we_q <= 1'b1;
                flags_q    <= flags_in;
                flags_q[SXE_ZERO_BIT] <= (xor_acc_mem == '0);
            end else if (go && op_in == SXE_OP_XORI) begin
                flags_we_q <= 1'b1;
                flags_q    <= flags_in;
                flags_q[SXE_ZERO_BIT] <= (xor_acc_imm == '0);
            end
        end
    end

    assign busy_out     = (state_q != SXE_ST_EXEC);
    assign flush_out    = flush_q;
    assign mem_we_out   = mem_we_q;
    assign mem_wd_out   = mem_wd_q;
    assign rom_re_out   = rom_re_q;
    assign rom_addr_out = rom_addr_q;
    assign acc_out      = acc_q;
    assign tab_hi_out   = tab_hi_q;
    assign flags_we_out = flags_we_q;
    assign flags_out    = flags_q;

    //////////////////////////////////////////////////////////////////////////
    // Checks. Every property lives in the core clock domain, so one
    // default clock and one default reset serve them all.
    default clocking cb @(posedge clk_in);
    endclocking

    default disable iff (!rstn_s);

    sequence s_skip_issue;
        go && skip;
    endsequence

    sequence s_dummy;
        flush_q && busy_out ##1 !busy_out;
    endsequence

    sequence s_table_issue;
        go && (op_in == SXE_OP_TRDC || op_in == SXE_OP_TRDL);
    endsequence

    sequence s_table_fill;
        rom_re_q && busy_out ##1 mem_we_q && !busy_out;
    endsequence

    AST_SKIP_TWO: assert property (s_skip_issue |=> s_dummy)
        else $error("Skip did not take exactly one dummy cycle.");

    AST_NOSKIP_ONE: assert property (
        go && op_in == SXE_OP_SKZ && !byte_zero |=> !busy_out && !flush_q)
        else $error("Non-zero byte test stalled.");

    AST_SKIP_QUIET: assert property (
        go && (op_in == SXE_OP_SKZ || op_in == SXE_OP_CPSKZ ||
               op_in == SXE_OP_BITSKZ) |=> !flags_we_q && !mem_we_q)
        else $error("Skip test touched flags or memory.");

    AST_FLUSH_CAUSE: assert property (
        flush_q |-> $past(go) && $past(skip))
        else $error("Flush without a met skip condition.");

    AST_BIT_SKIP: assert property (
        go && op_in == SXE_OP_BITSKZ |=> flush_q == $past(bit_zero))
        else $error("Bit test skip decision wrong.");

    AST_SWAP_ACC: assert property (
        go && op_in == SXE_OP_SWAP_ACC |=>
        acc_q == {$past(mem_rd_in[3:0]), $past(mem_rd_in[7:4])}
        && !mem_we_q && !flags_we_q)
        else $error("Swap to accumulator wrong.");

    AST_SWAP_MEM: assert property (
        go && op_in == SXE_OP_SWAP |=> mem_we_q && !flags_we_q
        && mem_wd_q == {$past(mem_rd_in[3:0]), $past(mem_rd_in[7:4])})
        else $error("Nibble swap write-back wrong.");

    AST_CPSKZ: assert property (
        go && op_in == SXE_OP_CPSKZ |=> acc_q == $past(mem_rd_in))
        else $error("Copy-and-test did not load accumulator.");

    AST_TABLE: assert property (
        go && op_in == SXE_OP_TRDL |=> rom_re_q
        && rom_addr_q[PC_W-1:DATA_W] == '1 ##1 mem_we_q)
        else $error("Last-page table read wrong.");

    AST_CUR_PAGE: assert property (
        go && op_in == SXE_OP_TRDC |=> rom_addr_q ==
        {$past(pc_in[PC_W-1:DATA_W]), $past(tab_ptr_in)})
        else $error("Current-page table address wrong.");

    AST_TABLE_SEQ: assert property (s_table_issue |=> s_table_fill)
        else $error("Table read did not fill in one extra cycle.");

    AST_TABLE_DATA: assert property (
        state_q == SXE_ST_TABLE |=> !flags_we_q
        && tab_hi_q == $past(rom_data_in[ROM_W-1:DATA_W])
        && mem_wd_q == $past(rom_data_in[DATA_W-1:0]))
        else $error("Table word split wrong.");

    AST_XOR_ACC: assert property (
        go && op_in == SXE_OP_XORA |=> acc_q == $past(xor_acc_mem)
        && flags_we_q && !mem_we_q)
        else $error("Register XOR wrong.");

    AST_XOR_MEM: assert property (
        go && op_in == SXE_OP_XOR_MEM |=> acc_q == $past(acc_q)
        && mem_wd_q == $past(xor_acc_mem) && flags_we_q
        && flags_q[SXE_ZERO_BIT] == ($past(xor_acc_mem) == '0))
        else $error("Memory XOR wrong.");

    AST_ZFLAG: assert property (
        go && op_in == SXE_OP_XORI |=> flags_we_q
        && flags_q[SXE_ZERO_BIT] == ($past(xor_acc_imm) == '0)
        && flags_q[3] == $past(flags_in[3])
        && flags_q[1:0] == $past(flags_in[1:0]))
        else $error("Zero flag update wrong.");
endmodule

/* File: verilog/sxe_pkg.sv */
// Package for the swap, skip, table read and exclusive-OR execution slice.
// Assumes an 8-bit data path and 15-bit program-memory words.
package sxe_pkg;
    localparam int SXE_DATA_W   = 8;
    localparam int SXE_ROM_W    = 15;
    localparam int SXE_PC_W     = 12;
    localparam int SXE_PAGE_W   = 8;
    localparam int SXE_BIT_W    = 3;
    localparam int SXE_ZERO_BIT = 2;
    localparam int SXE_FLAG_W   = 4;
    localparam logic [7:0] SXE_ACC_RST  = 8'h00;
    localparam logic [6:0] SXE_TABHI_RST = 7'h00;
    localparam logic [3:0] SXE_FLAG_RST = 4'h0;
    localparam logic [3:0] SXE_OP_W     = 4'h4;
    localparam int SXE_SKIP_CYC = 2;
    localparam int SXE_RUN_CYC  = 1;

    typedef enum logic [3:0] {
        SXE_OP_NOP    = 4'h0,
        SXE_OP_SWAP   = 4'h1,
        SXE_OP_SWAP_ACC = 4'h2,
        SXE_OP_SKZ    = 4'h3,
        SXE_OP_CPSKZ  = 4'h4,
        SXE_OP_BITSKZ = 4'h5,
        SXE_OP_TRDC   = 4'h6,
        SXE_OP_TRDL   = 4'h7,
        SXE_OP_XORA   = 4'h8,
        SXE_OP_XOR_MEM = 4'h9,
        SXE_OP_XORI   = 4'hA
    } sxe_op_e;

    typedef enum logic [2:0] {
        SXE_ST_EXEC  = 3'h1,
        SXE_ST_DUMMY = 3'h2,
        SXE_ST_TABLE = 3'h4
    } sxe_state_e;
endpackage

/* File: verilog/sxe_rst_sync.sv */
// Two-flop reset release synchroniser.
// Assumes one clock; assertion is asynchronous, release is clocked.
`timescale 1ns/1ps
module sxe_rst_sync (
    input  wire logic clk_in,   // Core clock.
    input  wire logic rstn_in,  // Raw active-low reset.
    output logic      rstn_out  // Synchronised active-low reset.
);
    logic stage1_q;
    logic stage2_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign rstn_out = stage2_q;
endmodule

/* File: tb/sxe_exec_tb.sv */
// Self-checking bench for the swap, skip, table read and XOR slice.
// Drives every input itself at the falling edge; no partner model.
`timescale 1ns/1ps
module sxe_exec_tb;
    import sxe_pkg::*;
    logic        clk_in, rstn_in, issue_in;
    logic [3:0]  op_in, flags_in, flags_out;
    logic [2:0]  bit_sel_in;
    logic [7:0]  imm_in, mem_rd_in, tab_ptr_in, mem_wd_out, acc_out;
    logic [11:0] pc_in, rom_addr_out;
    logic [14:0] rom_data_in;
    logic        busy_out, flush_out, mem_we_out, rom_re_out, flags_we_out;
    logic [6:0]  tab_hi_out;
    logic        s_we, s_fwe, s_rre, t_we;
    logic [7:0]  s_wd, s_acc, t_wd, exp_acc;
    logic [3:0]  s_fl;
    logic [11:0] s_addr;
    logic [6:0]  t_hi;
    int          fails, comparisons;

    sxe_exec sxe_exec_inst (.clk_in(clk_in), .rstn_in(rstn_in),
        .issue_in(issue_in), .op_in(op_in), .bit_sel_in(bit_sel_in),
        .imm_in(imm_in), .mem_rd_in(mem_rd_in), .pc_in(pc_in),
        .tab_ptr_in(tab_ptr_in), .rom_data_in(rom_data_in),
        .flags_in(flags_in),
        .busy_out(busy_out), .flush_out(flush_out),
        .mem_we_out(mem_we_out), .mem_wd_out(mem_wd_out),
        .rom_re_out(rom_re_out), .rom_addr_out(rom_addr_out),
        .acc_out(acc_out), .tab_hi_out(tab_hi_out),
        .flags_we_out(flags_we_out), .flags_out(flags_out));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chkv(input string n, input logic [11:0] e, g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkb(input string n, input logic e, g);
        chkv(n, {11'h000, e}, {11'h000, g});
    endtask

    // Issues one operation, checks the skip handshake over two cycles and
    // keeps what the first and second cycles show for the caller.
    task automatic run(input logic [3:0] op, input logic [7:0] m,
                       input logic [2:0] b, input logic fl, bz);
        @(negedge clk_in);
        op_in = op;
        mem_rd_in = m;
        bit_sel_in = b;
        issue_in = 1'b1;
        @(negedge clk_in);
        issue_in = 1'b0;
        {s_we, s_wd, s_acc, s_fwe, s_fl} =
            {mem_we_out, mem_wd_out, acc_out, flags_we_out, flags_out};
        {s_rre, s_addr} = {rom_re_out, rom_addr_out};
        chkb("flush c1", fl, flush_out);
        chkb("busy c1", bz, busy_out);
        @(negedge clk_in);
        chkb("flush c2", 1'b0, flush_out);
        chkb("busy c2", 1'b0, busy_out);
        {t_we, t_wd, t_hi} = {mem_we_out, mem_wd_out, tab_hi_out};
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_swap();
        run(SXE_OP_SWAP, 8'h3C, 3'h0, 1'b0, 1'b0);
        chkb("swap we", 1'b1, s_we);
        chkv("swap wd", 12'h0C3, 12'(s_wd));
        chkb("swap fwe", 1'b0, s_fwe);
        run(SXE_OP_SWAP_ACC, 8'hA5, 3'h0, 1'b0, 1'b0);
        exp_acc = 8'h5A;
        chkv("swap acc acc", 12'(exp_acc), 12'(s_acc));
        chkb("swap acc we", 1'b0, s_we);
        chkb("swap acc fwe", 1'b0, s_fwe);
    endtask

    task automatic t_skip();
        logic [7:0] m;
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 8'h00 : ((i == 1) ? 8'h01 : 8'h80);
            run(SXE_OP_SKZ, m, 3'h0, m == 8'h00, m == 8'h00);
            chkb("skz fwe", 1'b0, s_fwe);
            chkb("skz we", 1'b0, s_we);
            run(SXE_OP_CPSKZ, m, 3'h0, m == 8'h00, m == 8'h00);
            exp_acc = m;
            chkv("cpskz acc", 12'(exp_acc), 12'(s_acc));
            chkb("cpskz fwe", 1'b0, s_fwe);
        end
    endtask

    task automatic t_bitskip();
        for (int i = 0; i < 8; i++) begin
            run(SXE_OP_BITSKZ, 8'hFF ^ (8'h01 << i), 3'(i), 1'b1, 1'b1);
            run(SXE_OP_BITSKZ, 8'h01 << i, 3'(i), 1'b0, 1'b0);
            chkb("bit fwe", 1'b0, s_fwe);
        end
    endtask

    task automatic t_table(input logic [3:0] op, input logic [14:0] w,
                           input logic [11:0] a);
        rom_data_in = w;
        run(op, 8'h00, 3'h0, 1'b0, 1'b1);
        chkb("rom re", 1'b1, s_rre);
        chkv("rom addr", a, s_addr);
        chkb("tbl we", 1'b1, t_we);
        chkv("tbl wd", 12'(w[7:0]), 12'(t_wd));
        chkv("tbl high", 12'(w[14:8]), 12'(t_hi));
        chkb("tbl fwe", 1'b0, s_fwe);
    endtask

    // Zero flag follows the result; the other three come from flags_in.
    task automatic t_xor(input logic [3:0] op, input logic [7:0] v,
                         input logic [3:0] fin);
        logic [7:0] r;
        logic [3:0] ef;
        r = exp_acc ^ v;
        ef = fin;
        ef[SXE_ZERO_BIT] = (r == 8'h00);
        imm_in = v;
        flags_in = fin;
        run(op, v, 3'h0, 1'b0, 1'b0);
        if (op == SXE_OP_XOR_MEM) begin
            chkb("xor mem we", 1'b1, s_we);
            chkv("xor mem wd", 12'(r), 12'(s_wd));
        end else begin
            exp_acc = r;
            chkb("xor we", 1'b0, s_we);
        end
        chkv("xor acc", 12'(exp_acc), 12'(s_acc));
        chkb("xor fwe", 1'b1, s_fwe);
        chkv("xor flags", 12'(ef), 12'(s_fl));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn_in, issue_in, op_in, flags_in, bit_sel_in} = '0;
        {imm_in, mem_rd_in, rom_data_in} = '0;
        pc_in = 12'h5AB;
        tab_ptr_in = 8'h34;
        fails = 0;
        comparisons = 0;
        exp_acc = SXE_ACC_RST;
        repeat (12) @(posedge clk_in);
        chkv("reset acc", 12'(SXE_ACC_RST), 12'(acc_out));
        @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (3) @(posedge clk_in);
        t_swap();
        t_skip();
        t_bitskip();
        t_table(SXE_OP_TRDC, 15'h5A7E, 12'h534);
        t_table(SXE_OP_TRDL, 15'h2581, 12'hF34);
        t_xor(SXE_OP_XORA, exp_acc, 4'hB);
        t_xor(SXE_OP_XORI, 8'h96, 4'h4);
        t_xor(SXE_OP_XOR_MEM, 8'h96, 4'hB);
        t_xor(SXE_OP_XOR_MEM, 8'h0F, 4'hF);
        t_xor(SXE_OP_XORA, 8'h0F, 4'h0);
        t_xor(SXE_OP_XORI, 8'h99, 4'h0);
        close_out();
    end

    // A hung run is cut short and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        close_out();
    end
endmodule
